// ===== rtl/lcd_segment_common_scanner.sv
// lcd segment/common scanner with display memory and apb register slave
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "lcd_scan_map.svh"
module lcd_segment_common_scanner
  import lcd_scan_pkg::*;
#(
  parameter int DIV_LOG2 = `LCD_DIV_SLOW_LOG2, // slowest divider exponent
  parameter bit EMULATION = 1'b0, // gate register steers the clock when set
  parameter int SEGMENTS = `LCD_MEM_BYTES, // number of segment lines
  parameter int COMMONS = `LCD_COMMONS // number of common lines
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [17:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic [COMMONS-1:0][1:0] com_level_o,
  output logic [SEGMENTS-1:0][1:0] seg_level_o,
  output logic lcd_power_o,
  output logic panel_scan_clock_o
);

  //////////////////////////////////////////////////////////////////////////
  // declarations

  localparam int NW = `LCD_NIBBLE_W;

  logic [NW-1:0] mem_reg [SEGMENTS]; // display nibbles, index 0 = fa64
  logic [7:0] mode_reg; // display enable and scan clock select
  logic [7:0] power_reg; // drive supply select
  logic [7:0] gate_reg; // emulation clock gate, never read back
  bus_state_t bus_reg; // apb slave phase
  logic [31:0] prdata_reg; // captured read word
  logic pslverr_reg; // error answer flag
  logic [DIV_LOG2-1:0] div_reg; // scan clock prescaler
  logic scan_clk_reg; // visible scan clock, half a period high
  slot_t slot_reg; // active common slot
  logic pol_reg; // ac phase of the frame
  logic [SEGMENTS-1:0] col_reg; // sampled column for the slot
  logic [COMMONS-1:0][1:0] com_reg; // registered common levels
  logic [SEGMENTS-1:0][1:0] seg_reg; // registered segment levels

  logic [15:0] idx; // word index of the access
  logic in_mem; // index falls on display memory
  logic [4:0] mem_sel; // memory word of the access
  logic mapped; // index names a register
  logic access; // completing apb transfer
  logic wr_en; // write takes effect this edge
  logic running; // scanner clock supplied
  logic [2:0] sel_code; // scan clock select field
  logic [1:0] div_shift; // divider shortening for the code
  logic [DIV_LOG2-1:0] div_top; // last prescaler count
  logic scan_tick; // one scan period elapsed
  slot_t slot_next; // slot after the tick
  logic [SEGMENTS-1:0] col_next; // column for the next slot
  logic [31:0] rd_word; // read mux result

  lcd_phase_if phase ();

  //////////////////////////////////////////////////////////////////////////
  // apb decode

  // one wait state: the answer is registered, so pready rises on the
  // second access cycle together with read data and error flag
  always_comb begin
    idx = paddr_i[17:2];
    in_mem = (idx >= `LCD_MEM_FIRST_IDX) && (idx <= `LCD_MEM_LAST_IDX);
    mem_sel = 5'(idx - `LCD_MEM_FIRST_IDX);
    mapped = in_mem || (idx == `LCD_MODE_IDX) || (idx == `LCD_POWER_IDX)
      || (idx == `LCD_GATE_IDX) || (idx == `LCD_STATUS_IDX);
    access = psel_i && penable_i && (bus_reg == BUS_WAIT);
    wr_en = access && pwrite_i && pstrb_i[0] && mapped
      && (paddr_i[1:0] == 2'b00) && (idx != `LCD_STATUS_IDX);
  end

  // read mux; reserved bits read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (in_mem) begin
      rd_word[NW-1:0] = mem_reg[mem_sel];
    end else if (idx == `LCD_MODE_IDX) begin
      rd_word[7:0] = mode_reg;
    end else if (idx == `LCD_POWER_IDX) begin
      rd_word[7:0] = power_reg;
    end else if (idx == `LCD_STATUS_IDX) begin
      rd_word[`LCD_STAT_SLOT_HI:`LCD_STAT_SLOT_LO] = slot_reg;
      rd_word[`LCD_STAT_POL_BIT] = pol_reg;
      rd_word[`LCD_STAT_RUN_BIT] = running;
    end else begin
      // gate register is write-only and reads zero
      rd_word = 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // apb slave phase and answer

  // wait entered on the first access cycle, left when pready is shown
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_reg <= BUS_IDLE;
    end else begin
      case (bus_reg)
        BUS_IDLE: begin
          if (psel_i && penable_i) begin
            bus_reg <= BUS_WAIT;
          end
        end
        BUS_WAIT: begin
          bus_reg <= BUS_IDLE;
        end
        default: begin
          bus_reg <= BUS_IDLE;
        end
      endcase
    end
  end

  // answer registers; unmapped or misaligned words give pslverr
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (bus_reg == BUS_IDLE && psel_i && penable_i) begin
      prdata_reg <= pwrite_i ? 32'h0000_0000 : rd_word;
      pslverr_reg <= !mapped || (paddr_i[1:0] != 2'b00)
        || (pwrite_i && idx == `LCD_STATUS_IDX);
    end else begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register file

  // display memory keeps only the low nibble; upper bits have no storage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < SEGMENTS; i++) begin
        mem_reg[i] <= 4'h0;
      end
    end else if (wr_en && in_mem) begin
      mem_reg[mem_sel] <= pwdata_i[NW-1:0];
    end
  end

  // mode register: enable and divider select, low bits fixed zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_reg <= `LCD_MODE_RESET;
    end else if (wr_en && idx == `LCD_MODE_IDX) begin
      mode_reg <= {pwdata_i[7:4], 4'h0};
    end
  end

  // power register: only the supply select bit is stored
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      power_reg <= `LCD_POWER_RESET;
    end else if (wr_en && idx == `LCD_POWER_IDX) begin
      power_reg <= {7'h00, pwdata_i[`LCD_POWER_BIT]};
    end
  end

  // clock gate register; write-only, reset to zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gate_reg <= `LCD_GATE_RESET;
    end else if (wr_en && idx == `LCD_GATE_IDX) begin
      gate_reg <= pwdata_i[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // scan clock

  // production parts ignore the gate; emulation builds obey bit 1
  always_comb begin
    running = !EMULATION || gate_reg[`LCD_GATE_EN_BIT];
    sel_code = mode_reg[`LCD_MODE_SEL_HI:`LCD_MODE_SEL_LO];
    // prohibited codes fall back to the slowest rate, the safe choice
    div_shift = (sel_code <= `LCD_SEL_FASTEST) ? sel_code[1:0] : 2'b00;
    div_top = {DIV_LOG2{1'b1}} >> div_shift;
    scan_tick = running && (div_reg == div_top);
  end

  // prescaler: wraps every 2^(DIV_LOG2-code) main clocks
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_reg <= '0;
    end else if (!running) begin
      div_reg <= div_reg; // clock stopped, controller halts
    end else if (scan_tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // observable scan clock: high in the second half of each period
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scan_clk_reg <= 1'b0;
    end else begin
      scan_clk_reg <= running && (div_reg > (div_top >> 1));
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // common slot sequencer and column sampling

  // next slot and its column, taken from one memory snapshot
  always_comb begin
    slot_next = slot_reg + 2'b01;
    for (int n = 0; n < SEGMENTS; n++) begin
      // segment n reads the byte counted down from the top index
      col_next[n] = mem_reg[SEGMENTS-1-n][slot_next];
    end
  end

  // one slot per scan period, four slots per frame
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      slot_reg <= 2'b00;
    end else if (scan_tick) begin
      slot_reg <= slot_next;
    end
  end

  // polarity flips when the last common slot ends
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pol_reg <= 1'b0;
    end else if (scan_tick && slot_reg == 2'b11) begin
      pol_reg <= !pol_reg;
    end
  end

  // whole column captured in one edge, so a cpu write in mid slot
  // shows only from the next slot onward
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      col_reg <= '0;
    end else if (scan_tick) begin
      col_reg <= col_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // level encoding

  assign phase.polarity = pol_reg;
  assign phase.blank = !mode_reg[`LCD_MODE_EN_BIT];

  logic [COMMONS-1:0][1:0] com_lvl; // encoder outputs, commons
  logic [SEGMENTS-1:0][1:0] seg_lvl; // encoder outputs, segments

  // one encoder per common line; only the active slot is selected
  for (genvar c = 0; c < COMMONS; c++) begin : g_com
    level_t lvl;
    lcd_level_encoder u_enc (
      .phase (phase),
      .select_i (slot_reg == slot_t'(c)),
      .is_common_i (1'b1),
      .level_o (lvl)
    );
    assign com_lvl[c] = lvl;
  end

  // one encoder per segment line
  for (genvar s = 0; s < SEGMENTS; s++) begin : g_seg
    level_t lvl;
    lcd_level_encoder u_enc (
      .phase (phase),
      .select_i (col_reg[s]),
      .is_common_i (1'b0),
      .level_o (lvl)
    );
    assign seg_lvl[s] = lvl;
  end

  // output registers; lines change one clock after slot or phase
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      com_reg <= '0;
      seg_reg <= '0;
    end else begin
      com_reg <= com_lvl;
      seg_reg <= seg_lvl;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata_o = prdata_reg;
  assign pready_o = bus_reg == BUS_WAIT ? 1'b1 : 1'b0;
  assign pslverr_o = pslverr_reg;
  assign com_level_o = com_reg;
  assign seg_level_o = seg_reg;
  assign lcd_power_o = power_reg[`LCD_POWER_BIT];
  assign panel_scan_clock_o = scan_clk_reg;

endmodule

// ===== pkg/lcd_scan_map.svh
// offsets, field positions, reset values and timing counts of the lcd scanner
`ifndef LCD_SCAN_MAP_SVH
`define LCD_SCAN_MAP_SVH

// register indices; byte address on the bus is four times the index
`define LCD_MEM_FIRST_IDX 16'hfa64
`define LCD_MEM_LAST_IDX 16'hfa7f
`define LCD_MODE_IDX 16'hff90
`define LCD_POWER_IDX 16'hff92
`define LCD_GATE_IDX 16'hff93
`define LCD_STATUS_IDX 16'hff94

// display memory geometry
`define LCD_MEM_BYTES 28
`define LCD_COMMONS 4
`define LCD_NIBBLE_W 4

// mode register fields
`define LCD_MODE_EN_BIT 7
`define LCD_MODE_SEL_HI 6
`define LCD_MODE_SEL_LO 4
`define LCD_MODE_RESET 8'h00

// power register fields
`define LCD_POWER_BIT 0
`define LCD_POWER_RESET 8'h00

// clock gating register fields
`define LCD_GATE_EN_BIT 1
`define LCD_GATE_RESET 8'h00

// status register fields
`define LCD_STAT_SLOT_LO 0
`define LCD_STAT_SLOT_HI 1
`define LCD_STAT_POL_BIT 2
`define LCD_STAT_RUN_BIT 3

// scan clock divider: main clock over 2^17 at select code 000
`define LCD_DIV_SLOW_LOG2 17
`define LCD_SEL_FASTEST 3'h3

`endif

// ===== pkg/lcd_scan_pkg.sv
// types shared by the lcd scanner modules
package lcd_scan_pkg;

  // drive level of one panel line, in thirds of the drive voltage
  typedef enum logic [1:0] {
    LVL_GND = 2'b00,
    LVL_THIRD = 2'b01,
    LVL_TWO_THIRD = 2'b10,
    LVL_FULL = 2'b11
  } level_t;

  // common slot index inside one frame
  typedef logic [1:0] slot_t;

  // bus slave phase
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_WAIT = 1'b1
  } bus_state_t;

endpackage

// ===== pkg/lcd_phase_if.sv
// frame phase shared between the scanner and its level encoders
`timescale 1ns/1ps
interface lcd_phase_if;
  logic polarity; // current ac drive phase
  logic blank; // force segment lines to non-selection
  modport drv (output polarity, output blank);
  modport enc (input polarity, input blank);
endinterface

// ===== rtl/lcd_level_encoder.sv
// maps one select bit and the frame phase to a 1/3 bias drive level
`timescale 1ns/1ps
module lcd_level_encoder
  import lcd_scan_pkg::*;
(
  lcd_phase_if.enc phase,
  input wire logic select_i,
  input wire logic is_common_i,
  output level_t level_o
);

  level_t base; // level in the positive phase

  // positive phase: common sel full, common non-sel 1/3, segment sel gnd,
  // segment non-sel 2/3; only sel against sel spans the full voltage
  always_comb begin
    if (is_common_i) begin
      base = select_i ? LVL_FULL : LVL_THIRD;
    end else if (select_i && !phase.blank) begin
      base = LVL_GND;
    end else begin
      base = LVL_TWO_THIRD;
    end
    // negative phase mirrors every level about the mid rail
    if (phase.polarity) begin
      level_o = level_t'(~base);
    end else begin
      level_o = base;
    end
  end

endmodule

// ===== test/lcd_scan_asserts.sv
// concurrent checks on the ports of the lcd scanner
`timescale 1ns/1ps
`include "lcd_scan_map.svh"
module lcd_scan_asserts #(
  parameter int DIV_LOG2 = 4,
  parameter int SEGMENTS = 28,
  parameter int COMMONS = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [17:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [COMMONS-1:0][1:0] com_level_o,
  input wire logic [SEGMENTS-1:0][1:0] seg_level_o,
  input wire logic lcd_power_o,
  input wire logic panel_scan_clock_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [COMMONS-1:0] com_sel; // commons at an outer level
  logic [COMMONS-1:0] com_sel_reg; // last cycle view
  logic pos_phase; // selected common sits at full
  logic seg_odd_any; // some segment on an odd code
  logic seg_odd_all; // every segment on an odd code
  logic [2:0] up_reg; // edges since reset, saturating
  logic [31:0] hold_reg; // cycles since the slot moved
  logic live; // outputs carry encoded levels by now
  logic [15:0] idx; // word index on the bus
  assign idx = paddr_i[17:2];
  assign live = (up_reg == 3'h4);
  ////////////////////////////////////////////////////////////////
  // decode commons and segment parity
  always_comb begin
    pos_phase = 1'b0;
    seg_odd_any = 1'b0;
    seg_odd_all = 1'b1;
    for (int c = 0; c < COMMONS; c++) begin
      com_sel[c] = (com_level_o[c] == 2'h3) || (com_level_o[c] == 2'h0);
      pos_phase = pos_phase | (com_level_o[c] == 2'h3);
    end
    for (int n = 0; n < SEGMENTS; n++) begin
      seg_odd_any = seg_odd_any | seg_level_o[n][0];
      seg_odd_all = seg_odd_all & seg_level_o[n][0];
    end
  end
  // outputs hold their reset zeros up to the first edge; four edges are waited out
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      up_reg <= 3'h0;
    end else if (up_reg != 3'h4) begin
      up_reg <= up_reg + 3'h1;
    end
  end
  // slot length counter
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      com_sel_reg <= '0;
      hold_reg <= '0;
    end else begin
      com_sel_reg <= com_sel;
      hold_reg <= (com_sel != com_sel_reg) ? 32'h0 : hold_reg + 32'h1;
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence slot_move;
    live && (com_sel != $past(com_sel));
  endsequence
  sequence access_start;
    psel_i && $rose(penable_i);
  endsequence
  one_common_a: assert property (live |-> $onehot(com_sel))
    else $error("not exactly one common selected");
  common_order_a: assert property (slot_move |->
    com_sel == {$past(com_sel[2:0]), $past(com_sel[3])})
    else $error("commons out of order");
  seg_phase_a: assert property (live |->
    (pos_phase ? !seg_odd_any : seg_odd_all))
    else $error("segment level wrong for phase");
  frame_flip_a: assert property (live && $rose(com_sel[0]) |->
    pos_phase != $past(pos_phase))
    else $error("polarity kept across frame");
  slot_short_a: assert property (slot_move |=> $stable(com_sel))
    else $error("slot shorter than two cycles");
  slot_long_a: assert property (live |-> hold_reg < (32'h1 << (DIV_LOG2 + 1)))
    else $error("slot held too long");
  ready_wait_a: assert property (access_start |=> pready_o)
    else $error("ready not after one wait");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready held two cycles");
  idle_zero_a: assert property (!pready_o |-> prdata_o == 32'h0 && !pslverr_o)
    else $error("read data outside answer");
  nibble_zero_a: assert property (pready_o && !pwrite_i && paddr_i[1:0] == 2'h0 &&
    idx >= `LCD_MEM_FIRST_IDX && idx <= `LCD_MEM_LAST_IDX |-> prdata_o[31:4] == 28'h0)
    else $error("memory upper bits not zero");
  gate_read_a: assert property (pready_o && !pwrite_i && idx == `LCD_GATE_IDX &&
    paddr_i[1:0] == 2'h0 |-> prdata_o == 32'h0)
    else $error("gate register readable");
  power_hold_a: assert property ($changed(lcd_power_o) |->
    $past(pready_o && pwrite_i && idx == `LCD_POWER_IDX))
    else $error("power changed without write");
  scan_clock_a: assert property (slot_move |-> $fell(panel_scan_clock_o))
    else $error("slot moved off the scan clock edge");
endmodule
bind lcd_segment_common_scanner lcd_scan_asserts #(.DIV_LOG2(DIV_LOG2),
  .SEGMENTS(SEGMENTS), .COMMONS(COMMONS)) i_asserts (.clk_i(clk_i), .rst_i(rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .com_level_o(com_level_o), .seg_level_o(seg_level_o), .lcd_power_o(lcd_power_o),
  .panel_scan_clock_o(panel_scan_clock_o));

// ===== test/lcd_panel_model.sv
// passive glass: a pixel lights only at full swing between its lines
`timescale 1ns/1ps
module lcd_panel_model #(
  parameter int SEGMENTS = 28,
  parameter int COMMONS = 4
) (
  input wire logic [COMMONS-1:0][1:0] com_level_i,
  input wire logic [SEGMENTS-1:0][1:0] seg_level_i,
  output logic [COMMONS-1:0][SEGMENTS-1:0] pixel_on_o
);
  // a third of a swing stays dark, either sign of full swing lights
  always_comb begin
    for (int c = 0; c < COMMONS; c++) begin
      for (int n = 0; n < SEGMENTS; n++) begin
        // only gnd against full is a full swing; one-third against two-thirds is not
        pixel_on_o[c][n] = (com_level_i[c] == 2'h3 && seg_level_i[n] == 2'h0)
          || (com_level_i[c] == 2'h0 && seg_level_i[n] == 2'h3);
      end
    end
  end
endmodule

// ===== test/tb_top.sv
// self-checking bench for the lcd scanner
`timescale 1ns/1ps
`include "lcd_scan_map.svh"
module tb_top;
  import lcd_scan_pkg::*;
  localparam int DIV = 4; // short divider, slot is 16>>code clocks
  typedef struct packed {logic [17:0] a; logic [31:0] d; logic [31:0] r; logic e;} row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [17:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0;
  logic [3:0] pstrb_i = 4'hf; // all byte lanes on
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [3:0][1:0] com_level_o;
  logic [27:0][1:0] seg_level_o;
  logic lcd_power_o;
  logic [3:0][27:0] pixel_on; // lit map from the glass
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic er;
  int len;
  `define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
    $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
  // rows: address, write data, read back, error expected
  row_t rows [9] = '{
    '{{`LCD_MEM_LAST_IDX, 2'b00}, 32'hff, 32'hf, 1'b0},
    '{{`LCD_MEM_FIRST_IDX, 2'b00}, 32'h5a, 32'ha, 1'b0},
    '{{`LCD_POWER_IDX, 2'b00}, 32'h1, 32'h1, 1'b0},
    '{{`LCD_GATE_IDX, 2'b00}, 32'h2, 32'h0, 1'b0},
    '{{16'hff91, 2'b00}, 32'h11, 32'h0, 1'b1},
    '{{16'hfa63, 2'b00}, 32'h1, 32'h0, 1'b1},
    '{{16'hfa80, 2'b00}, 32'h1, 32'h0, 1'b1},
    '{{`LCD_MEM_FIRST_IDX, 2'b01}, 32'h1, 32'h0, 1'b1},
    '{{`LCD_MODE_IDX, 2'b00}, 32'hbf, 32'hb0, 1'b0}};
  ////////////////////////////////////////////////////////////////
  always #50 clk_i = ~clk_i;
  lcd_segment_common_scanner #(.DIV_LOG2(DIV)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .com_level_o(com_level_o), .seg_level_o(seg_level_o),
    .lcd_power_o(lcd_power_o), .panel_scan_clock_o());
  lcd_panel_model i_panel (.com_level_i(com_level_o), .seg_level_i(seg_level_o),
    .pixel_on_o(pixel_on));
  ////////////////////////////////////////////////////////////////
  // display nibble kept for segment n, repeating every 16 lines
  function automatic logic [3:0] pat(input int n);
    return 4'(n * 7 + 1);
  endfunction
  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // no local limit: only the bench timeout ends a hung wait
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // slot found from the commons, segments and glass follow the nibbles
  task automatic check_frames(input logic en);
    int k;
    logic b;
    logic [1:0] ex;
    logic [3:0] p;
    repeat (16) begin
      @(negedge clk_i);
      k = -1;
      for (int c = 0; c < 4; c++) if (com_level_o[c] == 2'h3 || com_level_o[c] == 2'h0) k = c;
      `CHK(k >= 0, 1'b1)
      if (k >= 0) begin
        for (int n = 0; n < 28; n++) begin
          p = pat(n);
          b = en & p[k];
          ex = b ? 2'h0 : 2'h2;
          if (com_level_o[k] == 2'h0) ex = 2'h3 - ex;
          `CHK(seg_level_o[n], ex)
          `CHK(pixel_on[k][n], b)
          for (int c = 0; c < 4; c++) if (c != k) `CHK(pixel_on[c][n], 1'b0)
        end
      end
    end
  endtask
  // cycles between two moves of the commons
  task automatic slot_len();
    logic [3:0][1:0] last;
    last = com_level_o;
    len = 0;
    do begin @(negedge clk_i); len++; end while (com_level_o === last && len < 64);
    last = com_level_o;
    len = 0;
    do begin @(negedge clk_i); len++; end while (com_level_o === last && len < 64);
  endtask
  task automatic give_verdict();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // hang guard, well above the fewer than one thousand cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      `CHK(er, rows[i].e)
      apb(1'b0, rows[i].a, 32'h0);
      `CHK(er, rows[i].e)
      if (!rows[i].e) `CHK(rd, rows[i].r)
    end
    pstrb_i <= 4'he; // lane 0 off: the write must be dropped
    apb(1'b1, {`LCD_MEM_LAST_IDX, 2'b00}, 32'h0);
    pstrb_i <= 4'hf;
    apb(1'b0, {`LCD_MEM_LAST_IDX, 2'b00}, 32'h0);
    `CHK(rd, 32'hf)
    $display("register rows done");
    apb(1'b1, {`LCD_GATE_IDX, 2'b00}, 32'h0);
    apb(1'b0, {`LCD_STATUS_IDX, 2'b00}, 32'h0);
    `CHK(rd[31:3], 29'h1)
    for (int n = 0; n < 28; n++) apb(1'b1, {`LCD_MEM_LAST_IDX - 16'(n), 2'b00}, 32'(pat(n)));
    apb(1'b1, {`LCD_MODE_IDX, 2'b00}, 32'hb0);
    repeat (40) @(posedge clk_i);
    check_frames(1'b1);
    $display("scan on done");
    apb(1'b1, {`LCD_MODE_IDX, 2'b00}, 32'h30);
    repeat (40) @(posedge clk_i);
    check_frames(1'b0);
    $display("scan off done");
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, {`LCD_MODE_IDX, 2'b00}, 32'h80 | 32'(c << 4));
      slot_len();
      `CHK(len, (1 << DIV) >> c)
    end
    $display("scan rates done");
    for (int n = 0; n < 28; n++) begin
      apb(1'b0, {`LCD_MEM_LAST_IDX - 16'(n), 2'b00}, 32'h0);
      `CHK(rd, 32'(pat(n)))
    end
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int n = 0; n < 28; n++) begin
      apb(1'b0, {`LCD_MEM_LAST_IDX - 16'(n), 2'b00}, 32'h0);
      `CHK(rd, 32'h0)
    end
    $display("reset clear done");
    give_verdict();
  end
endmodule
